// *** tb/amon_props.sv ***
/*
  checker: port relations of the monitor channel select.
  assumes it is bound onto the top module, one clock domain.
*/
`default_nettype none

module amon_props import monitor_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire mon_ctrl_s i_ctrl,
  input wire logic i_system_on,
  input wire logic [5:0] i_buck_at_1v8,
  input wire switch_ctrl_s o_switch,
  input wire logic o_reserved_code,
  input wire logic o_settled
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire logic act = i_ctrl.monitor_out_enable & i_system_on;
  wire logic [4:0] sel = i_ctrl.monitor_channel_select;
  wire logic idle = (o_switch.channel_onehot == '0) && !o_switch.buffer_enable;
  AST_PARK: assert property (!i_ctrl.monitor_out_enable |=> idle && o_switch.pulldown_enable)
    else $error("monitor not parked");
  AST_HIZ: assert property (act && sel == 5'h00 |=> idle && !o_switch.pulldown_enable)
    else $error("code zero not high impedance");
  AST_RSV: assert property (act && sel > 5'h18 |=> idle && o_reserved_code)
    else $error("reserved code not isolated");
  AST_AON: assert property (act && sel == 5'h02 |=> o_switch.channel_onehot == 24'h000002
    && o_switch.divider == DIV_3P5) else $error("always-on rail route wrong");
  AST_BUCK: assert property (act && sel inside {[5'h04:5'h09]} |=>
    o_switch.divider == ($past(i_buck_at_1v8[sel - 5'h04]) ? DIV_1P25 : DIV_1))
    else $error("buck divider wrong");
  AST_B7: assert property (act && sel == 5'h0A |=> o_switch.divider == DIV_2P86)
    else $error("buck 7 divider wrong");
  AST_LDO: assert property (act && sel inside {[5'h0B:5'h0E]} |=>
    o_switch.divider == DIV_3P33 && o_switch.buffer_enable) else $error("ldo route wrong");
  AST_TEMP: assert property (act && sel inside {[5'h0F:5'h18]} |=>
    o_switch.divider == DIV_1 && o_switch.buffer_enable) else $error("sensor route wrong");
  AST_SYSOFF: assert property (!i_system_on |=> idle && o_switch.pulldown_enable)
    else $error("output live outside system on");
  AST_SETTLE_DROP: assert property (act && sel != 5'h00 && sel <= 5'h18 && $changed(sel)
    |=> !o_settled) else $error("settled kept across a channel change");
  AST_SETTLE_LIVE: assert property (o_settled |-> o_switch.buffer_enable)
    else $error("settled while not routed");
endmodule

`default_nettype wire

// *** tb/host_model.sv ***
/*
  host software model: drives the enable bit, select code and system-on level.
  assumes calls come just after a rising edge.
*/
`default_nettype none

module host_model import monitor_pkg::*; (
  input wire logic i_clk,
  output var mon_ctrl_s o_ctrl,
  output var logic o_system_on
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_ctrl = '0;
    o_system_on = 1'b0;
  end
  // ==========================================================================
  // software writes: 5-bit code, reserved codes only when a test insists
  task automatic set(input logic en, input logic [4:0] sel, input logic on);
    o_ctrl.monitor_out_enable = en;
    o_ctrl.monitor_channel_select = sel;
    o_system_on = on;
  endtask
  // reader holds off sampling for n rising clock edges
  task automatic hold_off(input int n);
    repeat (n) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
/*
  testbench: parking, every select code, system-off and settle timing.
  assumes the design package and host model are compiled first.
*/
`default_nettype none

module tb_top import monitor_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SC = 8;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [5:0] buck = 6'h00;
  mon_ctrl_s ctrl;
  logic son;
  switch_ctrl_s sw;
  logic rsv;
  logic settled;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #4 i_clk = ~i_clk;
  host_model host_model_i (.i_clk, .o_ctrl(ctrl), .o_system_on(son));
  analog_monitor_channel_select #(.SETTLE_CYC(SC)) analog_monitor_channel_select_i (
    .i_clk, .i_rstn, .i_ctrl(ctrl), .i_system_on(son), .i_buck_at_1v8(buck),
    .o_switch(sw), .o_reserved_code(rsv), .o_settled(settled));
  // ==========================================================================
  // helpers
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic switch_ctrl_s exp_sw(input logic act, input logic [4:0] s,
                                          input logic [5:0] b);
    switch_ctrl_s e;
    e = '{channel_onehot: '0, divider: DIV_NONE, buffer_enable: 1'b0, pulldown_enable: !act};
    if (act && s != 5'h00 && s <= 5'h18) begin
      e.channel_onehot = 24'h000001 << (s - 5'h01);
      e.buffer_enable = 1'b1;
      if (s == 5'h01) e.divider = DIV_4;
      else if (s == 5'h02) e.divider = DIV_3P5;
      else if (s == 5'h03) e.divider = DIV_3;
      else if (s <= 5'h09) e.divider = b[s - 5'h04] ? DIV_1P25 : DIV_1;
      else if (s == 5'h0A) e.divider = DIV_2P86;
      else if (s <= 5'h0E) e.divider = DIV_3P33;
      else e.divider = DIV_1;
    end
    return e;
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_park();
    chk(32'(sw), 32'(SWITCH_RESET));
    host_model_i.set(1'b0, 5'h05, 1'b1);
    step();
    chk(32'(sw), 32'(exp_sw(1'b0, 5'h05, buck)));
    $display("test park done");
  endtask
  task automatic t_codes();
    buck = 6'h15;
    for (int i = 0; i < 32; i++) begin
      host_model_i.set(1'b1, 5'(i), 1'b1);
      step();
      chk(32'(sw), 32'(exp_sw(1'b1, 5'(i), buck)));
      chk(32'(rsv), 32'(i > 24));
    end
    $display("test codes done");
  endtask
  task automatic t_sysoff();
    host_model_i.set(1'b1, 5'h01, 1'b0);
    step();
    chk(32'(sw), 32'(exp_sw(1'b0, 5'h01, buck)));
    host_model_i.set(1'b1, 5'h01, 1'b1);
    step();
    chk(32'(sw), 32'(exp_sw(1'b1, 5'h01, buck)));
    $display("test system off done");
  endtask
  task automatic t_settle();
    host_model_i.set(1'b1, 5'h04, 1'b1);
    step();
    host_model_i.hold_off(SC - 1);
    #1;
    chk(32'(settled), 32'h0);
    step();
    chk(32'(settled), 32'h1);
    host_model_i.set(1'b1, 5'h05, 1'b1);
    step();
    chk(32'(settled), 32'h0);
    $display("test settle done");
  endtask
  // ==========================================================================
  // sequence and hang guard; 2000 cycles is far above the expected run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    t_park();
    t_codes();
    t_sysoff();
    t_settle();
    report_and_stop();
  end
endmodule

bind analog_monitor_channel_select amon_props amon_props_i (.i_clk, .i_rstn, .i_ctrl,
  .i_system_on, .i_buck_at_1v8, .o_switch, .o_reserved_code, .o_settled);

`default_nettype wire

// *** verilog/analog_monitor_channel_select.sv ***
/*
  analog monitor channel select: turns the enable bit and the 5-bit select into
  switch, divider, buffer and pull-down controls for the monitor multiplexer.
  assumes the control bits, system-on level and buck settings come from logic on
  i_clk; the analog switches and the pin driver sit outside this module.
*/
`default_nettype none

module analog_monitor_channel_select import monitor_pkg::*; #(
  parameter int SETTLE_CYC = SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire mon_ctrl_s i_ctrl,
  input wire logic i_system_on,
  input wire logic [5:0] i_buck_at_1v8,
  output switch_ctrl_s o_switch,
  output logic o_reserved_code,
  output logic o_settled
);

  // ==========================================================================
  // decode helpers
  function automatic logic is_reserved(input logic [SEL_W-1:0] code);
    return code > SEL_TEMP_LAST;
  endfunction

  function automatic logic [CHAN_N-1:0] chan_decode(input logic [SEL_W-1:0] code);
    logic [CHAN_N-1:0] oh;
    oh = '0;
    // code 0 and reserved codes close no switch
    if (code != SEL_OFF && !is_reserved(code)) begin
      oh[code - SEL_VIN] = 1'b1;
    end
    return oh;
  endfunction

  function automatic divider_e div_decode(input logic [SEL_W-1:0] code,
                                          input logic [5:0] at_1v8);
    divider_e d;
    logic [SEL_W-1:0] idx;
    d = DIV_NONE;
    idx = code - SEL_BUCK_FIRST;
    if (code == SEL_VIN) begin
      d = DIV_4;
    end else if (code == SEL_AON) begin
      d = DIV_3P5;
    end else if (code == SEL_CELL) begin
      d = DIV_3;
    end else if (code >= SEL_BUCK_FIRST && code <= SEL_BUCK_LAST) begin
      d = at_1v8[idx[2:0]] ? DIV_1P25 : DIV_1;
    end else if (code == SEL_BUCK7) begin
      d = DIV_2P86;
    end else if (code >= SEL_LDO_FIRST && code <= SEL_LDO_LAST) begin
      d = DIV_3P33;
    end else if (code >= SEL_TEMP_DIE && code <= SEL_TEMP_LAST) begin
      d = DIV_1;
    end
    return d;
  endfunction

  // ==========================================================================
  // state
  mon_state_e state_q;
  mon_state_e state_d;
  logic [SEL_W-1:0] sel_q;
  logic [SEL_W-1:0] sel_d;
  switch_ctrl_s switch_q;
  switch_ctrl_s switch_d;
  logic reserved_q;
  logic reserved_d;
  logic restart;
  logic routed_next;

  // ==========================================================================
  // next state and switch controls
  always_comb begin
    state_d = ST_PARKED;
    sel_d = sel_q;
    reserved_d = 1'b0;
    // outside system-on the pin is parked like a disabled monitor
    if (!i_ctrl.monitor_out_enable || !i_system_on) begin
      state_d = ST_PARKED;
    end else if (i_ctrl.monitor_channel_select == SEL_OFF) begin
      state_d = ST_HIZ;
    end else if (is_reserved(i_ctrl.monitor_channel_select)) begin
      state_d = ST_HIZ;
      reserved_d = 1'b1;
    end else begin
      state_d = ST_ROUTED;
      sel_d = i_ctrl.monitor_channel_select;
    end
  end

  always_comb begin
    switch_d = SWITCH_RESET;
    unique case (state_d)
      ST_PARKED: begin
        // select is ignored entirely here
        switch_d.pulldown_enable = 1'b1;
      end
      ST_HIZ: begin
        switch_d.pulldown_enable = 1'b0;
      end
      ST_ROUTED: begin
        switch_d.pulldown_enable = 1'b0;
        switch_d.buffer_enable = 1'b1;
        switch_d.channel_onehot = chan_decode(i_ctrl.monitor_channel_select);
        switch_d.divider = div_decode(i_ctrl.monitor_channel_select, i_buck_at_1v8);
      end
    endcase
  end

  // a fresh route or a channel change restarts the settle wait
  always_comb begin
    routed_next = (state_d == ST_ROUTED);
    restart = routed_next && ((state_q != ST_ROUTED) ||
              (sel_q != i_ctrl.monitor_channel_select));
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q <= ST_PARKED;
      sel_q <= SEL_OFF;
      switch_q <= SWITCH_RESET;
      reserved_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      switch_q <= switch_d;
      reserved_q <= reserved_d;
    end
  end

  // ==========================================================================
  // settle indication for the reader
  settle_timer #(
    .CYCLES(SETTLE_CYC)
  ) u_settle (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_active(routed_next),
    .i_restart(restart),
    .o_done(o_settled)
  );

  assign o_switch = switch_q;
  assign o_reserved_code = reserved_q;

endmodule

`default_nettype wire

// *** verilog/monitor_pkg.sv ***
/*
  constants, types and select codes for the analog monitor channel select logic.
  assumes the control bits come from register logic on the same clock.
*/
`default_nettype none

package monitor_pkg;

  localparam int SEL_W = 5;
  localparam int CHAN_N = 24;

  // ==========================================================================
  // select codes
  localparam logic [4:0] SEL_OFF = 5'h00;
  localparam logic [4:0] SEL_VIN = 5'h01;
  localparam logic [4:0] SEL_AON = 5'h02;
  localparam logic [4:0] SEL_CELL = 5'h03;
  localparam logic [4:0] SEL_BUCK_FIRST = 5'h04;
  localparam logic [4:0] SEL_BUCK_LAST = 5'h09;
  localparam logic [4:0] SEL_BUCK7 = 5'h0A;
  localparam logic [4:0] SEL_LDO_FIRST = 5'h0B;
  localparam logic [4:0] SEL_LDO_LAST = 5'h0E;
  localparam logic [4:0] SEL_TEMP_DIE = 5'h0F;
  localparam logic [4:0] SEL_TEMP_FIRST = 5'h10;
  localparam logic [4:0] SEL_TEMP_LAST = 5'h18;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 125;
  localparam int SETTLE_TIME_US = 50;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
  localparam int SETTLE_W = 13;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    DIV_NONE = 3'h0,
    DIV_1 = 3'h1,
    DIV_1P25 = 3'h2,
    DIV_2P86 = 3'h3,
    DIV_3 = 3'h4,
    DIV_3P33 = 3'h5,
    DIV_3P5 = 3'h6,
    DIV_4 = 3'h7
  } divider_e;

  typedef enum logic [2:0] {
    ST_PARKED = 3'b001,
    ST_HIZ = 3'b010,
    ST_ROUTED = 3'b100
  } mon_state_e;

  typedef struct packed {
    logic monitor_out_enable;
    logic [SEL_W-1:0] monitor_channel_select;
  } mon_ctrl_s;

  typedef struct packed {
    logic [CHAN_N-1:0] channel_onehot;
    divider_e divider;
    logic buffer_enable;
    logic pulldown_enable;
  } switch_ctrl_s;

  localparam switch_ctrl_s SWITCH_RESET = '{
    channel_onehot: '0, divider: DIV_NONE, buffer_enable: 1'b0, pulldown_enable: 1'b1};

endpackage

`default_nettype wire

// *** verilog/settle_timer.sv ***
/*
  settle timer: counts the output settling time after each restart.
  assumes restart and active come from logic on the same clock.
*/
`default_nettype none

module settle_timer import monitor_pkg::*; #(
  parameter int CYCLES = SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_active,
  input wire logic i_restart,
  output logic o_done
);

  logic [SETTLE_W-1:0] count_q;
  logic [SETTLE_W-1:0] count_d;
  logic done_q;
  logic done_d;

  // ==========================================================================
  // countdown
  always_comb begin
    count_d = count_q;
    done_d = done_q;
    if (!i_active) begin
      count_d = '0;
      done_d = 1'b0;
    end else if (i_restart) begin
      count_d = SETTLE_W'(CYCLES - 1);
      done_d = 1'b0;
    end else if (count_q != '0) begin
      count_d = count_q - SETTLE_W'(1);
    end else begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      count_q <= '0;
      done_q <= 1'b0;
    end else begin
      count_q <= count_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;

endmodule

`default_nettype wire
